// ==== hw/sfcd_pkg.sv ====
package sfcd_pkg;

  // opcodes, sent msb first
  localparam logic [7:0] OP_READ_STATUS   = 8'h05;
  localparam logic [7:0] OP_READ_FLAG     = 8'h70;
  localparam logic [7:0] OP_READ_CONFIG   = 8'hb5;
  localparam logic [7:0] OP_READ_BYTES    = 8'h03;
  localparam logic [7:0] OP_FAST_READ     = 8'h0b;
  localparam logic [7:0] OP_FAST_READ_DL  = 8'hbb;
  localparam logic [7:0] OP_FAST_READ_QL  = 8'heb;
  localparam logic [7:0] OP_WRITE_ENABLE  = 8'h06;
  localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
  localparam logic [7:0] OP_WRITE_STATUS  = 8'h01;
  localparam logic [7:0] OP_WRITE_CONFIG  = 8'hb1;
  localparam logic [7:0] OP_WRITE_BYTES   = 8'h02;
  localparam logic [7:0] OP_WRITE_DL      = 8'hd2;
  localparam logic [7:0] OP_WRITE_QL      = 8'h12;
  localparam logic [7:0] OP_WRITE_QL_ALT  = 8'h38;
  localparam logic [7:0] OP_ERASE_BULK    = 8'hc7;
  localparam logic [7:0] OP_ERASE_SECTOR  = 8'hd8;
  localparam logic [7:0] OP_WIDE_ENTRY    = 8'hb7;
  localparam logic [7:0] OP_WIDE_EXIT     = 8'he9;

  // address lengths in bits
  localparam logic [5:0] ADDR_BITS_NARROW = 6'h18;
  localparam logic [5:0] ADDR_BITS_WIDE   = 6'h20;

  // dummy cycles
  localparam logic [3:0] DUMMY_DEFAULT    = 4'h8;
  localparam logic [3:0] DUMMY_DEFAULT_QL = 4'ha;
  localparam int         CFG_DUMMY_LSB    = 12;

  // register bit positions and reset values
  localparam int          STAT_BUSY_BIT   = 0;
  localparam int          STAT_WEL_BIT    = 1;
  localparam int          FLAG_READY_BIT  = 7;
  localparam int          FLAG_WIDE_BIT   = 0;
  localparam logic [15:0] CFG_RESET       = 16'hffff;
  localparam logic [5:0]  STAT_USER_RESET = 6'h00;
  localparam logic [8:0]  PAGE_BYTES      = 9'h100;

  // slow read clock ceiling; host side limit, not checked here
  localparam int READ_BYTES_FMAX_MHZ = 50;

  // kinds of self-timed operation handed out at deselect
  typedef enum logic [2:0] {
    SFCD_KIND_NONE   = 3'b000,
    SFCD_KIND_PAGE   = 3'b001,
    SFCD_KIND_STATUS = 3'b010,
    SFCD_KIND_CONFIG = 3'b011,
    SFCD_KIND_BULK   = 3'b100,
    SFCD_KIND_SECTOR = 3'b101
  } sfcd_kind_t;

  typedef enum logic [2:0] {
    SFCD_ST_OPCODE  = 3'b000,
    SFCD_ST_ADDR    = 3'b001,
    SFCD_ST_DUMMY   = 3'b010,
    SFCD_ST_OUT     = 3'b011,
    SFCD_ST_DATA_IN = 3'b100,
    SFCD_ST_IGNORE  = 3'b101
  } sfcd_state_t;

endpackage : sfcd_pkg

// ==== hw/sfcd_pin_sync.sv ====
`timescale 1ns/1ns
// two-stage synchronisers for the pins, plus serial clock edge pulses
module sfcd_pin_sync (
  input  wire logic       mclk,
  input  wire logic       reset,
  input  wire logic [2:0] pins_in,
  output logic      [2:0] pins_sync,
  output logic            clk_rise,
  output logic            clk_fall
);

  logic [2:0] stage1_reg;
  logic       clk_prev_reg;

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_sync
      always_ff @(posedge mclk) begin
        if (reset) begin
          stage1_reg[gi] <= (gi == 0) ? 1'b1 : 1'b0;
          pins_sync[gi]  <= (gi == 0) ? 1'b1 : 1'b0;
        end else begin
          stage1_reg[gi] <= pins_in[gi];
          pins_sync[gi]  <= stage1_reg[gi];
        end
      end
    end
  endgenerate

  // edges are found on the second stage only
  always_ff @(posedge mclk) begin
    if (reset) begin
      clk_prev_reg <= 1'b0;
    end else begin
      clk_prev_reg <= pins_sync[1];
    end
  end

  assign clk_rise = pins_sync[1] & ~clk_prev_reg;
  assign clk_fall = ~pins_sync[1] & clk_prev_reg;

endmodule : sfcd_pin_sync

// ==== hw/sfcd_decoder.sv ====
`timescale 1ns/1ns
// How it works
// - opcode bits arrive on serial_in_line msb first
// - status and flag reads take no address, no dummy, return bytes
// - status and data reads repeat output bytes until deselect
// - configuration read returns two bytes of the 16-bit value
// - after sixteen configuration bits the output line is held at zero
// - plain read has address, no dummy; host keeps clock at or below 50 MHz
// - address latched on rising edges, data out msb first on falling edges
// - three address bytes in narrow mode, four in wide mode
// - read address advances per byte and wraps to zero
// - data read opcodes are ignored while a write or erase runs; status, flag and config reads still answer
// - fast reads take address then dummy cycles, data repeats
// - dummy count configurable, default 8, or 10 for quad
// - write enable sets the latch
// - write disable or completed self-timed operation clears the latch
// - page write takes 1 to 256 bytes, last 256 win
// - dual and quad page writes take address and 1 to 256 bytes
// - wide entry and exit opcodes carry no address or data
// - flag bit 0 shows wide addressing mode
// - flag bit 7 is zero while busy, one when ready
module sfcd_decoder (
  input  wire logic        mclk,
  input  wire logic        reset,
  input  wire logic        chip_select_n,
  input  wire logic        serial_clock,
  input  wire logic        serial_in_line,
  output logic             serial_out_line,
  output logic             serial_out_en_n,
  output logic             mem_rd_req,
  output logic      [31:0] mem_rd_addr,
  input  wire logic [7:0]  mem_rd_data,
  output logic             page_wr_valid,
  output logic      [31:0] page_wr_addr,
  output logic      [7:0]  page_wr_data,
  output logic             op_start,
  output logic      [2:0]  op_kind,
  output logic      [31:0] op_addr,
  input  wire logic        op_busy,
  input  wire logic        op_done,
  output logic             wide_mode,
  output logic             write_enable_latch,
  output logic      [15:0] config_value
);

  logic [2:0] pins_sync;
  logic       clk_rise;
  logic       clk_fall;

  sfcd_pin_sync u_sync (
    .mclk      (mclk),
    .reset     (reset),
    .pins_in   ({serial_in_line, serial_clock, chip_select_n}),
    .pins_sync (pins_sync),
    .clk_rise  (clk_rise),
    .clk_fall  (clk_fall)
  );

  logic cs_n_s;
  logic din_s;
  assign cs_n_s = pins_sync[0];
  assign din_s  = pins_sync[2];

  sfcd_pkg::sfcd_state_t state_reg;
  logic [7:0]  opcode_reg;
  logic [7:0]  in_shift_reg;
  logic [5:0]  bit_cnt_reg;
  logic [31:0] addr_reg;
  logic [3:0]  dummy_left_reg;
  logic [8:0]  byte_cnt_reg;
  logic [7:0]  page_off_reg;
  logic [7:0]  out_shift_reg;
  logic [2:0]  out_bit_cnt_reg;
  logic [1:0]  out_byte_idx_reg;
  logic        load_pending_reg;
  logic        load_now_reg;
  logic        erase_armed_reg;
  logic [15:0] cfg_shadow_reg;
  logic [5:0]  stat_user_reg;
  logic [5:0]  stat_shadow_reg;
  logic        cs_n_d_reg;

  logic [7:0]  rx_byte;
  logic        byte_done;
  logic [5:0]  addr_bits;
  logic        addr_done;
  logic [3:0]  dummy_cnt;
  logic [31:0] addr_inc;
  logic        is_read_op;
  logic        is_page_op;
  logic        deselect_edge;
  logic [7:0]  status_byte;
  logic [7:0]  flag_byte;

  assign rx_byte   = {in_shift_reg[6:0], din_s};
  assign byte_done = clk_rise && (bit_cnt_reg[2:0] == 3'h7);
  assign addr_bits = wide_mode ? sfcd_pkg::ADDR_BITS_WIDE : sfcd_pkg::ADDR_BITS_NARROW;
  assign addr_done = clk_rise && (bit_cnt_reg == addr_bits - 6'h01);
  assign is_read_op = (rx_byte == sfcd_pkg::OP_READ_BYTES) || (rx_byte == sfcd_pkg::OP_FAST_READ) ||
                      (rx_byte == sfcd_pkg::OP_FAST_READ_DL) || (rx_byte == sfcd_pkg::OP_FAST_READ_QL);
  assign is_page_op = (opcode_reg == sfcd_pkg::OP_WRITE_BYTES) || (opcode_reg == sfcd_pkg::OP_WRITE_DL) ||
                      (opcode_reg == sfcd_pkg::OP_WRITE_QL) || (opcode_reg == sfcd_pkg::OP_WRITE_QL_ALT);
  assign deselect_edge = cs_n_s && !cs_n_d_reg;

  // field values 0 and f select the defaults
  always_comb begin
    dummy_cnt = config_value[sfcd_pkg::CFG_DUMMY_LSB +: 4];
    if (dummy_cnt == 4'h0 || dummy_cnt == 4'hf) begin
      dummy_cnt = (opcode_reg == sfcd_pkg::OP_FAST_READ_QL) ? sfcd_pkg::DUMMY_DEFAULT_QL
                                                            : sfcd_pkg::DUMMY_DEFAULT;
    end
  end

  // narrow mode wraps inside 24 bits
  assign addr_inc = wide_mode ? addr_reg + 32'h1 : {8'h00, addr_reg[23:0] + 24'h1};

  assign status_byte = {stat_user_reg, write_enable_latch, op_busy};
  assign flag_byte   = {!op_busy, 6'h00, wide_mode};

  always_ff @(posedge mclk) begin
    if (reset) begin
      cs_n_d_reg <= 1'b1;
    end else begin
      cs_n_d_reg <= cs_n_s;
    end
  end

  // command decode and input shifting
  always_ff @(posedge mclk) begin
    if (reset) begin
      state_reg      <= sfcd_pkg::SFCD_ST_OPCODE;
      opcode_reg     <= 8'h00;
      in_shift_reg   <= 8'h00;
      bit_cnt_reg    <= 6'h00;
      dummy_left_reg <= 4'h0;
    end else if (cs_n_s) begin
      state_reg   <= sfcd_pkg::SFCD_ST_OPCODE;
      bit_cnt_reg <= 6'h00;
    end else if (clk_rise) begin
      in_shift_reg <= rx_byte;
      bit_cnt_reg  <= bit_cnt_reg + 6'h01;
      case (state_reg)
        sfcd_pkg::SFCD_ST_OPCODE: begin
          if (byte_done) begin
            opcode_reg  <= rx_byte;
            bit_cnt_reg <= 6'h00;
            state_reg   <= sfcd_pkg::SFCD_ST_IGNORE;
            if (rx_byte == sfcd_pkg::OP_READ_STATUS || rx_byte == sfcd_pkg::OP_READ_FLAG ||
                rx_byte == sfcd_pkg::OP_READ_CONFIG) begin
              state_reg <= sfcd_pkg::SFCD_ST_OUT;
            end else if (is_read_op) begin
              if (!op_busy) begin
                state_reg <= sfcd_pkg::SFCD_ST_ADDR;
              end
            end else if (write_enable_latch) begin
              case (rx_byte)
                sfcd_pkg::OP_WRITE_BYTES, sfcd_pkg::OP_WRITE_DL, sfcd_pkg::OP_WRITE_QL,
                sfcd_pkg::OP_WRITE_QL_ALT, sfcd_pkg::OP_ERASE_SECTOR: begin
                  state_reg <= sfcd_pkg::SFCD_ST_ADDR;
                end
                sfcd_pkg::OP_WRITE_STATUS, sfcd_pkg::OP_WRITE_CONFIG: begin
                  state_reg <= sfcd_pkg::SFCD_ST_DATA_IN;
                end
                default: begin
                  state_reg <= sfcd_pkg::SFCD_ST_IGNORE;
                end
              endcase
            end
          end
        end
        sfcd_pkg::SFCD_ST_ADDR: begin
          if (addr_done) begin
            bit_cnt_reg    <= 6'h00;
            dummy_left_reg <= dummy_cnt;
            case (opcode_reg)
              sfcd_pkg::OP_READ_BYTES:   state_reg <= sfcd_pkg::SFCD_ST_OUT;
              sfcd_pkg::OP_ERASE_SECTOR: state_reg <= sfcd_pkg::SFCD_ST_IGNORE;
              sfcd_pkg::OP_FAST_READ, sfcd_pkg::OP_FAST_READ_DL,
              sfcd_pkg::OP_FAST_READ_QL: state_reg <= sfcd_pkg::SFCD_ST_DUMMY;
              default:                   state_reg <= sfcd_pkg::SFCD_ST_DATA_IN;
            endcase
          end
        end
        sfcd_pkg::SFCD_ST_DUMMY: begin
          dummy_left_reg <= dummy_left_reg - 4'h1;
          if (dummy_left_reg == 4'h1) begin
            state_reg <= sfcd_pkg::SFCD_ST_OUT;
          end
        end
        sfcd_pkg::SFCD_ST_OUT, sfcd_pkg::SFCD_ST_DATA_IN, sfcd_pkg::SFCD_ST_IGNORE: begin
          state_reg <= state_reg;
        end
        default: begin
          state_reg <= sfcd_pkg::SFCD_ST_IGNORE;
        end
      endcase
    end
  end

  // address capture and advance
  always_ff @(posedge mclk) begin
    if (reset) begin
      addr_reg     <= 32'h0;
      page_off_reg <= 8'h00;
    end else if (!cs_n_s && clk_rise && state_reg == sfcd_pkg::SFCD_ST_OPCODE) begin
      addr_reg <= 32'h0;
    end else if (!cs_n_s && clk_rise && state_reg == sfcd_pkg::SFCD_ST_ADDR) begin
      addr_reg     <= {addr_reg[30:0], din_s};
      page_off_reg <= {addr_reg[6:0], din_s};
    end else if (mem_rd_req) begin
      addr_reg <= addr_inc;
    end else if (page_wr_valid) begin
      page_off_reg <= page_off_reg + 8'h01;
    end
  end

  // entering output state or finishing a byte schedules the next load
  logic start_out;
  assign start_out = !cs_n_s && clk_rise &&
                     ((state_reg == sfcd_pkg::SFCD_ST_OPCODE && byte_done &&
                       (rx_byte == sfcd_pkg::OP_READ_STATUS || rx_byte == sfcd_pkg::OP_READ_FLAG ||
                        rx_byte == sfcd_pkg::OP_READ_CONFIG)) ||
                      (state_reg == sfcd_pkg::SFCD_ST_ADDR && addr_done &&
                       opcode_reg == sfcd_pkg::OP_READ_BYTES) ||
                      (state_reg == sfcd_pkg::SFCD_ST_DUMMY && dummy_left_reg == 4'h1));

  // memory requests are one-cycle pulses; data is taken the next cycle
  always_ff @(posedge mclk) begin
    if (reset) begin
      mem_rd_req       <= 1'b0;
      mem_rd_addr      <= 32'h0;
      load_pending_reg <= 1'b0;
      load_now_reg     <= 1'b0;
    end else begin
      mem_rd_req       <= 1'b0;
      load_pending_reg <= 1'b0;
      // second stage waits out the one-cycle memory latency
      load_now_reg     <= load_pending_reg;
      if (!cs_n_s && (start_out || (state_reg == sfcd_pkg::SFCD_ST_OUT && clk_fall &&
                                    out_bit_cnt_reg == 3'h7))) begin
        load_pending_reg <= 1'b1;
        if (opcode_reg != sfcd_pkg::OP_READ_STATUS && opcode_reg != sfcd_pkg::OP_READ_FLAG &&
            opcode_reg != sfcd_pkg::OP_READ_CONFIG && state_reg != sfcd_pkg::SFCD_ST_OPCODE) begin
          mem_rd_req  <= 1'b1;
          // last address bit reaches addr_reg only at this same edge
          mem_rd_addr <= (state_reg == sfcd_pkg::SFCD_ST_ADDR) ? {addr_reg[30:0], din_s} : addr_reg;
        end
      end
    end
  end

  // output shifter: changes on falling serial clock edges
  always_ff @(posedge mclk) begin
    if (reset) begin
      out_shift_reg    <= 8'h00;
      out_bit_cnt_reg  <= 3'h0;
      out_byte_idx_reg <= 2'h0;
      serial_out_line  <= 1'b0;
      serial_out_en_n  <= 1'b1;
    end else if (cs_n_s) begin
      out_bit_cnt_reg  <= 3'h0;
      out_byte_idx_reg <= 2'h0;
      serial_out_en_n  <= 1'b1;
    end else begin
      if (load_now_reg) begin
        case (opcode_reg)
          sfcd_pkg::OP_READ_STATUS: out_shift_reg <= status_byte;
          sfcd_pkg::OP_READ_FLAG:   out_shift_reg <= flag_byte;
          sfcd_pkg::OP_READ_CONFIG: begin
            case (out_byte_idx_reg)
              2'h0:    out_shift_reg <= config_value[7:0];
              2'h1:    out_shift_reg <= config_value[15:8];
              default: out_shift_reg <= 8'h00;
            endcase
          end
          default: out_shift_reg <= mem_rd_data;
        endcase
      end else if (clk_fall && state_reg == sfcd_pkg::SFCD_ST_OUT) begin
        serial_out_line <= out_shift_reg[7];
        serial_out_en_n <= 1'b0;
        out_shift_reg   <= {out_shift_reg[6:0], 1'b0};
        out_bit_cnt_reg <= out_bit_cnt_reg + 3'h1;
        if (out_bit_cnt_reg == 3'h7 && out_byte_idx_reg != 2'h3) begin
          out_byte_idx_reg <= out_byte_idx_reg + 2'h1;
        end
      end
    end
  end

  // incoming data bytes: page loads and register shadows
  always_ff @(posedge mclk) begin
    if (reset) begin
      page_wr_valid   <= 1'b0;
      page_wr_addr    <= 32'h0;
      page_wr_data    <= 8'h00;
      byte_cnt_reg    <= 9'h000;
      cfg_shadow_reg  <= sfcd_pkg::CFG_RESET;
      stat_shadow_reg <= sfcd_pkg::STAT_USER_RESET;
    end else begin
      page_wr_valid <= 1'b0;
      if (cs_n_s) begin
        if (!deselect_edge) begin
          byte_cnt_reg <= 9'h000;
        end
      end else if (byte_done && state_reg == sfcd_pkg::SFCD_ST_DATA_IN) begin
        if (byte_cnt_reg != sfcd_pkg::PAGE_BYTES) begin
          byte_cnt_reg <= byte_cnt_reg + 9'h001;
        end
        if (is_page_op) begin
          // offset wraps in the page, so later bytes overwrite earlier ones
          page_wr_valid <= 1'b1;
          page_wr_addr  <= {addr_reg[31:8], page_off_reg};
          page_wr_data  <= rx_byte;
        end else if (opcode_reg == sfcd_pkg::OP_WRITE_STATUS && byte_cnt_reg == 9'h000) begin
          stat_shadow_reg <= rx_byte[7:2];
        end else if (opcode_reg == sfcd_pkg::OP_WRITE_CONFIG) begin
          if (byte_cnt_reg == 9'h000) begin
            cfg_shadow_reg[7:0] <= rx_byte;
          end else if (byte_cnt_reg == 9'h001) begin
            cfg_shadow_reg[15:8] <= rx_byte;
          end
        end
      end
    end
  end

  // erase commands are armed at the end of their opcode or address
  always_ff @(posedge mclk) begin
    if (reset || cs_n_s) begin
      erase_armed_reg <= 1'b0;
    end else if ((byte_done && state_reg == sfcd_pkg::SFCD_ST_OPCODE &&
                  rx_byte == sfcd_pkg::OP_ERASE_BULK && write_enable_latch) ||
                 (addr_done && state_reg == sfcd_pkg::SFCD_ST_ADDR &&
                  opcode_reg == sfcd_pkg::OP_ERASE_SECTOR)) begin
      erase_armed_reg <= 1'b1;
    end
  end

  // self-timed work starts at deselect, only for complete commands
  always_ff @(posedge mclk) begin
    if (reset) begin
      op_start      <= 1'b0;
      op_kind       <= sfcd_pkg::SFCD_KIND_NONE;
      op_addr       <= 32'h0;
      config_value  <= sfcd_pkg::CFG_RESET;
      stat_user_reg <= sfcd_pkg::STAT_USER_RESET;
    end else begin
      op_start <= 1'b0;
      if (deselect_edge) begin
        op_addr <= addr_reg;
        if (erase_armed_reg) begin
          op_start <= 1'b1;
          op_kind  <= (opcode_reg == sfcd_pkg::OP_ERASE_BULK) ? sfcd_pkg::SFCD_KIND_BULK
                                                              : sfcd_pkg::SFCD_KIND_SECTOR;
        end else if (state_reg == sfcd_pkg::SFCD_ST_DATA_IN && byte_cnt_reg != 9'h000) begin
          if (is_page_op) begin
            op_start <= 1'b1;
            op_kind  <= sfcd_pkg::SFCD_KIND_PAGE;
          end else if (opcode_reg == sfcd_pkg::OP_WRITE_STATUS) begin
            op_start      <= 1'b1;
            op_kind       <= sfcd_pkg::SFCD_KIND_STATUS;
            stat_user_reg <= stat_shadow_reg;
          end else if (byte_cnt_reg[8:1] != 8'h00) begin
            op_start     <= 1'b1;
            op_kind      <= sfcd_pkg::SFCD_KIND_CONFIG;
            config_value <= cfg_shadow_reg;
          end
        end
      end
    end
  end

  // write enable latch and addressing mode
  logic opcode_seen;
  assign opcode_seen = !cs_n_s && byte_done && state_reg == sfcd_pkg::SFCD_ST_OPCODE;

  always_ff @(posedge mclk) begin
    if (reset) begin
      write_enable_latch <= 1'b0;
    end else if (opcode_seen && rx_byte == sfcd_pkg::OP_WRITE_ENABLE) begin
      write_enable_latch <= 1'b1;
    end else if ((opcode_seen && rx_byte == sfcd_pkg::OP_WRITE_DISABLE) || op_done) begin
      write_enable_latch <= 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      wide_mode <= 1'b0;
    end else if (opcode_seen && write_enable_latch) begin
      if (rx_byte == sfcd_pkg::OP_WIDE_ENTRY) begin
        wide_mode <= 1'b1;
      end else if (rx_byte == sfcd_pkg::OP_WIDE_EXIT) begin
        wide_mode <= 1'b0;
      end
    end
  end

  sequence s_opcode_in(logic [7:0] op);
    opcode_seen && rx_byte == op;
  endsequence

  a_read_blocked_busy: assert property (@(posedge mclk) disable iff (reset)
    s_opcode_in(sfcd_pkg::OP_READ_BYTES) and op_busy |=> state_reg == sfcd_pkg::SFCD_ST_IGNORE)
    else $error("read accepted while busy");

  a_wel_set_enable: assert property (@(posedge mclk) disable iff (reset)
    s_opcode_in(sfcd_pkg::OP_WRITE_ENABLE) |=> write_enable_latch)
    else $error("write enable did not set latch");

  a_wel_clear_disable: assert property (@(posedge mclk) disable iff (reset)
    s_opcode_in(sfcd_pkg::OP_WRITE_DISABLE) |=> !write_enable_latch)
    else $error("write disable did not clear latch");

  a_no_wel_ignored: assert property (@(posedge mclk) disable iff (reset)
    s_opcode_in(sfcd_pkg::OP_WRITE_BYTES) and !write_enable_latch
      |=> state_reg == sfcd_pkg::SFCD_ST_IGNORE && !page_wr_valid)
    else $error("page write accepted without latch");

  a_deselect_abort: assert property (@(posedge mclk) disable iff (reset)
    cs_n_s |=> state_reg == sfcd_pkg::SFCD_ST_OPCODE && bit_cnt_reg == 6'h00)
    else $error("deselect did not abort decode");

  a_addr_wrap_zero: assert property (@(posedge mclk) disable iff (reset)
    mem_rd_req && !wide_mode && addr_reg[23:0] == 24'hffffff |=> addr_reg == 32'h0)
    else $error("narrow address did not wrap");

  a_cfg_zero_tail: assert property (@(posedge mclk) disable iff (reset)
    opcode_reg == sfcd_pkg::OP_READ_CONFIG && load_now_reg && out_byte_idx_reg[1]
      |=> out_shift_reg == 8'h00)
    else $error("config read tail not zero");

  a_flag_fields: assert property (@(posedge mclk) disable iff (reset)
    opcode_reg == sfcd_pkg::OP_READ_FLAG && load_now_reg && !cs_n_s
      |=> out_shift_reg[0] == $past(wide_mode) && out_shift_reg[7] == !$past(op_busy))
    else $error("flag byte fields wrong");

  a_msb_first_out: assert property (@(posedge mclk) disable iff (reset)
    !cs_n_s && clk_fall && state_reg == sfcd_pkg::SFCD_ST_OUT && !load_now_reg
      |=> serial_out_line == $past(out_shift_reg[7]) ##1 !clk_fall[*2])
    else $error("output bit not msb first");

endmodule : sfcd_decoder

// ==== bench/sfcd_host.sv ====
`timescale 1ns/1ns
module sfcd_host (
  input  wire logic mclk,
  output logic      chip_select_n,
  output logic      serial_clock,
  output logic      serial_in_line,
  input  wire logic serial_out_line
);
  initial begin
    chip_select_n  = 1'b1;
    serial_clock   = 1'b0;
    serial_in_line = 1'b0;
  end
  task automatic wt(input int n);
    repeat (n) @(posedge mclk);
  endtask : wt
  // clock stands low outside frames; 20 mclk per half period
  task automatic xfer(input logic [63:0] tx, input int ntx, input int nrx, output logic [63:0] rx);
    rx = 64'h0;
    chip_select_n <= 1'b0;
    for (int i = 0; i < ntx + nrx; i++) begin
      serial_in_line <= (i < ntx) ? tx[ntx-1-i] : ~serial_in_line;
      wt(20);
      serial_clock <= 1'b1;
      if (i >= ntx) rx = {rx[62:0], serial_out_line};
      wt(20);
      serial_clock <= 1'b0;
    end
    wt(20);
    chip_select_n <= 1'b1;
    wt(40);
  endtask : xfer
endmodule : sfcd_host

// ==== bench/serial_flash_command_decoder_tb.sv ====
`timescale 1ns/1ns
module serial_flash_command_decoder_tb;
  typedef struct {
    logic [63:0] tx;
    int          ntx;
    int          nrx;
    logic [63:0] exp;
  } sfcd_row_t;
  logic        mclk = 1'b0;
  logic        reset = 1'b1;
  logic        chip_select_n, serial_clock, serial_in_line, serial_out_line, serial_out_en_n;
  logic        mem_rd_req, page_wr_valid, op_start, wide_mode, write_enable_latch;
  logic        op_busy = 1'b0;
  logic        op_done = 1'b0;
  logic [7:0]  mem_rd_data = 8'h00;
  logic [7:0]  page_wr_data;
  logic [31:0] mem_rd_addr, page_wr_addr, op_addr;
  logic [2:0]  op_kind;
  logic [15:0] config_value, wr_last;
  logic [63:0] rx;
  int          fails, cmp_count, rd_cnt, wr_cnt, st_cnt;
  sfcd_row_t   rows[20] = '{
    '{64'h05, 8, 16, 64'h0}, '{64'h06, 8, 0, 64'h0}, '{64'h05, 8, 16, 64'h0202},
    '{64'h70, 8, 16, 64'h8080}, '{64'hb5, 8, 24, 64'hffff00},
    '{64'h03fffffe, 32, 24, 64'ha4a55a}, '{64'h0b00001000, 40, 8, 64'h4a},
    '{64'hbb00001000, 40, 8, 64'h4a}, '{64'heb0000100000 >> 6, 42, 8, 64'h4a},
    '{64'h04, 8, 0, 64'h0}, '{64'h05, 8, 8, 64'h0}, '{64'hb7, 8, 0, 64'h0},
    '{64'h70, 8, 8, 64'h80}, '{64'h06, 8, 0, 64'h0}, '{64'hb7, 8, 0, 64'h0},
    '{64'h70, 8, 8, 64'h81}, '{64'h0300000003, 40, 16, 64'h595e}, '{64'h06, 8, 0, 64'h0},
    '{64'he9, 8, 0, 64'h0}, '{64'h70, 8, 8, 64'h80}};
  always #2 mclk = ~mclk;
  sfcd_host i_host (.mclk(mclk), .chip_select_n(chip_select_n), .serial_clock(serial_clock),
    .serial_in_line(serial_in_line), .serial_out_line(serial_out_line));
  sfcd_decoder i_dut (.mclk(mclk), .reset(reset), .chip_select_n(chip_select_n),
    .serial_clock(serial_clock), .serial_in_line(serial_in_line), .serial_out_line(serial_out_line),
    .serial_out_en_n(serial_out_en_n), .mem_rd_req(mem_rd_req), .mem_rd_addr(mem_rd_addr),
    .mem_rd_data(mem_rd_data), .page_wr_valid(page_wr_valid), .page_wr_addr(page_wr_addr),
    .page_wr_data(page_wr_data), .op_start(op_start), .op_kind(op_kind), .op_addr(op_addr),
    .op_busy(op_busy), .op_done(op_done), .wide_mode(wide_mode),
    .write_enable_latch(write_enable_latch), .config_value(config_value));
  // memory answers one mclk after the request; pattern makes each low address byte distinct
  always @(posedge mclk) begin
    if (mem_rd_req) mem_rd_data <= mem_rd_addr[7:0] ^ 8'h5a;
    if (mem_rd_req) rd_cnt++;
    if (page_wr_valid) wr_cnt++;
    if (page_wr_valid) wr_last <= {page_wr_addr[7:0], page_wr_data};
    if (op_start) st_cnt++;
  end
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : conclude
  initial begin
    #200000;
    fails++;
    conclude();
  end
  initial begin
    repeat (12) @(posedge mclk);
    reset <= 1'b0;
    i_host.wt(4);
    chk(64'(config_value), 64'hffff);
    foreach (rows[i]) begin
      i_host.xfer(rows[i].tx, rows[i].ntx, rows[i].nrx, rx);
      chk(rx, rows[i].exp);
    end
    // data read refused while a write runs; flag read still answers and shows busy
    op_busy <= 1'b1;
    rd_cnt = 0;
    i_host.xfer(64'h03000010, 32, 8, rx);
    chk(64'(rd_cnt), 64'h0);
    i_host.xfer(64'h70, 8, 8, rx);
    chk(rx, 64'h00);
    op_busy <= 1'b0;
    wr_cnt = 0;
    i_host.xfer(64'h06, 8, 0, rx);
    i_host.xfer(64'h020000101122, 48, 0, rx);
    chk(64'(wr_cnt), 64'h2);
    chk(64'(op_kind), 64'(sfcd_pkg::SFCD_KIND_PAGE));
    chk(64'(op_addr), 64'h10);
    chk(64'(wr_last), 64'h1122);
    op_done <= 1'b1;
    i_host.wt(1);
    op_done <= 1'b0;
    i_host.wt(2);
    chk(64'(write_enable_latch), 64'h0);
    i_host.xfer(64'h0200001033, 40, 0, rx);
    chk(64'(wr_cnt), 64'h2);
    // half an opcode then deselect; a leftover would turn 05 into 70
    i_host.xfer(64'h7, 4, 0, rx);
    i_host.xfer(64'h05, 8, 8, rx);
    chk(rx, 64'h00);
    i_host.xfer(64'h06, 8, 0, rx);
    i_host.xfer(64'hb1ff3f, 24, 0, rx);
    chk(64'({op_kind, config_value}), 64'h33fff);
    i_host.xfer(64'h0b000010 << 3, 35, 8, rx);
    chk(rx, 64'h4a);
    i_host.xfer(64'hc7, 8, 0, rx);
    chk(64'({op_kind, 4'(st_cnt)}), 64'h43);
    reset <= 1'b1;
    i_host.wt(12);
    reset <= 1'b0;
    i_host.wt(2);
    chk(64'({write_enable_latch, wide_mode, serial_out_en_n, config_value}), 64'h1ffff);
    conclude();
  end
endmodule : serial_flash_command_decoder_tb
